/* File: design/ddr_side_ctrl.sv */
// sideband controller: refresh, multicast, low power, ecc with read-modify-write
// Summary of operation
// - refresh request beats pending read or write
// - up to nine back-to-back refreshes per request
// - multicast on: refresh goes to all ranks
// - multicast write goes to every chip select
// - no multicast with registered dimm or ecc
// - finish pending accesses before self-refresh
// - ack and stay while request held
// - drop ack only after memory exits
// - power-down after programmed idle cycles
// - idle counter runs only with empty queue
// - assert power-down ack with the entry command
// - precharge power-down only, banks closed
// - 32-bit configuration port on controller clock
// - without port, settings fixed at build
// - secded codeword, one extra clock each way
// - any ecc error raises interrupt
// - single-bit error: internal read then write
// - double-bit error flag aligned with valid
// - stall everything during auto-correction
// - partial write with ecc on does read-merge-write
// - errors in merge read counted, word written
`timescale 1ns/1ps
`include "ddr_side_map.svh"

module ddr_side_ctrl #(
	parameter bit CSR_EN = 1'b1,
	parameter bit ECC_DEF = 1'b0,
	parameter bit AC_DEF = 1'b1,
	parameter bit MC_DEF = 1'b0,
	parameter bit RDIMM_DEF = 1'b0,
	parameter logic [15:0] PD_DEF = `PD_CYC_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// user read and write requests
	input wire logic user_valid,
	input wire ddr_side_pkg::user_req_t user_req,
	output logic user_ready,
	// user refresh
	input wire logic user_rfsh_req,
	input wire logic [ddr_side_pkg::NCS-1:0] user_rfsh_cs,
	input wire logic [3:0] user_rfsh_cnt,
	// low power handshakes
	input wire logic self_rfsh_req,
	output logic self_rfsh_ack,
	output logic powerdown_ack,
	// read data to user
	output logic rdata_valid,
	output logic [ddr_side_pkg::DW-1:0] rdata,
	output logic rdata_error,
	// configuration bits, 32-bit port word
	input wire logic [31:0] csr_cfg,
	// ecc status
	input wire logic sbe_flag_clr,
	output logic ecc_interrupt,
	output logic single_bit_flag_reg,
	output logic [15:0] sbe_count,
	output logic [15:0] dbe_count,
	output logic [ddr_side_pkg::AW-1:0] err_addr,
	// phy command and read return
	output ddr_side_pkg::mem_cmd_t mem_cmd,
	input wire logic phy_rd_valid,
	input wire logic [ddr_side_pkg::CW-1:0] phy_rd_code
);

	////////////////////////////////////////////////////////////////////////////
	// ecc code functions

	// encode: hamming bits at powers of two, overall parity in bit 0
	function automatic logic [39:0] ecc_enc(input logic [31:0] d);
		logic [39:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				c[p] = d[k];
				k++;
			end
		end
		for (int i = 0; i < 6; i++) begin
			for (int p = 3; p < 39; p++) begin
				if (p[i] && ((p & (p - 1)) != 0)) c[1 << i] = c[1 << i] ^ c[p];
			end
		end
		c[0] = ^c;
		return c;
	endfunction

	// decode: syndrome fixes one bit, flags two
	function automatic ddr_side_pkg::ecc_dec_t ecc_dec(input logic [39:0] c);
		logic [5:0] s;
		logic par;
		logic [39:0] f;
		int k;
		ddr_side_pkg::ecc_dec_t r;
		s = '0;
		f = c;
		k = 0;
		r = '0;
		par = ^c[38:0];
		for (int p = 1; p < 39; p++) begin
			for (int i = 0; i < 6; i++) begin
				if (p[i]) s[i] = s[i] ^ c[p];
			end
		end
		if (par && s < 6'h27) f[s] = ~f[s];
		r.sbe = par && (s < 6'h27);
		r.dbe = (!par && s != 6'h00) || (par && s >= 6'h27);
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				r.data[k] = f[p];
				k++;
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// configuration selection

	// word bits: 0 ecc, 1 auto-correct, 2 multicast, 3 rdimm, 31:16 pd cycles
	wire logic ecc_en = CSR_EN ? csr_cfg[0] : ECC_DEF;
	wire logic auto_correct_enable = CSR_EN ? csr_cfg[1] : AC_DEF;
	wire logic mc_en = CSR_EN ? csr_cfg[2] : MC_DEF;
	wire logic rdimm = CSR_EN ? csr_cfg[3] : RDIMM_DEF;
	wire logic [15:0] pd_cyc = CSR_EN ? csr_cfg[31:16] : PD_DEF;
	// multicast usable only on unbuffered, non-ecc setups
	wire logic mc_ok = mc_en && !rdimm && !ecc_en;

	////////////////////////////////////////////////////////////////////////////
	// state and registers

	ddr_side_pkg::state_t st_q, st_d; // controller state
	ddr_side_pkg::mem_cmd_t cmd_q, cmd_d; // command to phy
	ddr_side_pkg::user_req_t req_q, req_d; // request in flight
	logic [3:0] rfsh_left_q, rfsh_left_d; // refreshes still to send
	logic [7:0] srx_q, srx_d; // self-refresh exit wait
	logic pre_sr_q, pre_sr_d; // precharge leads to self-refresh
	logic sr_ack_q, sr_ack_d; // self-refresh ack
	logic pd_ack_q, pd_ack_d; // power-down ack
	logic ready_q; // request port open
	logic [15:0] idle_cnt_q; // idle cycles seen
	logic s1_v_q; // read pipe stage valid
	logic [39:0] s1_code_q; // read pipe stage codeword
	logic rdv_q, rde_q; // user read valid and error
	logic [31:0] rdata_q; // user read data
	logic irq_q, sbe_flag_q; // interrupt pulse, sticky flag
	logic [15:0] sbe_cnt_q, dbe_cnt_q; // error counters
	logic [23:0] err_addr_q; // last failing address

	////////////////////////////////////////////////////////////////////////////
	// decode wires

	wire logic take = user_valid && ready_q && !user_rfsh_req;
	wire logic be_full = &user_req.byte_enable_vector;
	wire logic quiet = (st_q == ddr_side_pkg::ST_IDLE) && !user_valid
		&& !user_rfsh_req && !self_rfsh_req;
	wire logic pd_go = quiet && (pd_cyc != 16'h0000) && (idle_cnt_q == pd_cyc);
	wire logic wake = user_valid || user_rfsh_req || self_rfsh_req;
	wire logic [3:0] rfsh_n = (user_rfsh_cnt > `RFSH_MAX) ? `RFSH_MAX :
		((user_rfsh_cnt == 4'h0) ? 4'h1 : user_rfsh_cnt);
	// read pipe: one stage more when ecc is on
	wire ddr_side_pkg::ecc_dec_t dec = ecc_dec(s1_code_q);
	wire logic rd_done = ecc_en ? s1_v_q : phy_rd_valid;
	wire logic [31:0] rd_data = ecc_en ? dec.data : phy_rd_code[31:0];
	wire logic sbe_w = ecc_en && s1_v_q && dec.sbe;
	wire logic dbe_w = ecc_en && s1_v_q && dec.dbe;
	wire logic [31:0] merged;

	// byte merge of new write data over corrected old word
	for (genvar i = 0; i < ddr_side_pkg::BW; i++) begin : g_merge
		assign merged[8*i +: 8] = req_q.byte_enable_vector[i] ?
			req_q.wdata[8*i +: 8] : rd_data[8*i +: 8];
	end

	////////////////////////////////////////////////////////////////////////////
	// next state and command

	always_comb begin
		st_d = st_q;
		cmd_d = '0;
		req_d = req_q;
		rfsh_left_d = rfsh_left_q;
		srx_d = srx_q;
		pre_sr_d = pre_sr_q;
		sr_ack_d = sr_ack_q;
		pd_ack_d = pd_ack_q;
		case (st_q)
			ddr_side_pkg::ST_IDLE: begin
				if (user_rfsh_req) begin
					// refresh first, to all ranks under multicast
					st_d = ddr_side_pkg::ST_RFSH;
					rfsh_left_d = rfsh_n;
					req_d.cs = mc_ok ? '1 : user_rfsh_cs;
				end else if (take) begin
					req_d = user_req;
					if (!user_req.is_wr || (ecc_en && !be_full)) begin
						// read, or read phase of a partial write
						cmd_d.kind = ddr_side_pkg::MC_RD;
						cmd_d.cs = user_req.cs;
						cmd_d.addr = user_req.addr;
						st_d = user_req.is_wr ? ddr_side_pkg::ST_RMW :
							ddr_side_pkg::ST_RD;
					end else if (ecc_en) begin
						// full write waits one clock for the encoder
						st_d = ddr_side_pkg::ST_ENC;
					end else begin
						// plain write, copied to all ranks if multicast
						cmd_d.kind = ddr_side_pkg::MC_WR;
						cmd_d.cs = (mc_ok && user_req.mc) ? '1 : user_req.cs;
						cmd_d.addr = user_req.addr;
						cmd_d.code = {8'h00, user_req.wdata};
						cmd_d.be = user_req.byte_enable_vector;
					end
				end else if (self_rfsh_req && !user_valid) begin
					// nothing in flight: close banks, then self-refresh
					cmd_d.kind = ddr_side_pkg::MC_PRE;
					cmd_d.cs = '1;
					pre_sr_d = 1'b1;
					st_d = ddr_side_pkg::ST_PRE;
				end else if (pd_go) begin
					// idle long enough: precharge all first
					cmd_d.kind = ddr_side_pkg::MC_PRE;
					cmd_d.cs = '1;
					pre_sr_d = 1'b0;
					st_d = ddr_side_pkg::ST_PRE;
				end
			end
			ddr_side_pkg::ST_RFSH: begin
				// one refresh per cycle until the run ends
				cmd_d.kind = ddr_side_pkg::MC_REF;
				cmd_d.cs = req_q.cs;
				rfsh_left_d = rfsh_left_q - 4'h1;
				if (rfsh_left_q == 4'h1) st_d = ddr_side_pkg::ST_IDLE;
			end
			ddr_side_pkg::ST_RD: begin
				if (rd_done) begin
					if (sbe_w && auto_correct_enable) begin
						// re-read failing word, write back with no new bytes
						cmd_d.kind = ddr_side_pkg::MC_RD;
						cmd_d.cs = req_q.cs;
						cmd_d.addr = req_q.addr;
						req_d.byte_enable_vector = '0;
						st_d = ddr_side_pkg::ST_RMW;
					end else begin
						st_d = ddr_side_pkg::ST_IDLE;
					end
				end
			end
			ddr_side_pkg::ST_RMW: begin
				// merge over the corrected or raw word, errors or not
				if (rd_done) begin
					req_d.wdata = merged;
					req_d.byte_enable_vector = '1;
					st_d = ddr_side_pkg::ST_ENC;
				end
			end
			ddr_side_pkg::ST_ENC: begin
				// write with freshly computed check bits
				cmd_d.kind = ddr_side_pkg::MC_WR;
				cmd_d.cs = req_q.cs;
				cmd_d.addr = req_q.addr;
				cmd_d.code = ecc_enc(req_q.wdata);
				cmd_d.be = '1;
				st_d = ddr_side_pkg::ST_IDLE;
			end
			ddr_side_pkg::ST_PRE: begin
				// enter the chosen low power mode, banks now closed
				cmd_d.kind = pre_sr_q ? ddr_side_pkg::MC_SRE : ddr_side_pkg::MC_PDE;
				cmd_d.cs = '1;
				sr_ack_d = pre_sr_q;
				pd_ack_d = !pre_sr_q;
				st_d = pre_sr_q ? ddr_side_pkg::ST_SREF : ddr_side_pkg::ST_PDN;
			end
			ddr_side_pkg::ST_PDN: begin
				// any request wakes the memory
				if (wake) begin
					cmd_d.kind = ddr_side_pkg::MC_PDX;
					cmd_d.cs = '1;
					pd_ack_d = 1'b0;
					st_d = ddr_side_pkg::ST_IDLE;
				end
			end
			ddr_side_pkg::ST_SREF: begin
				// held while the request stays high
				if (!self_rfsh_req) begin
					cmd_d.kind = ddr_side_pkg::MC_SRX;
					cmd_d.cs = '1;
					srx_d = `SRX_CYC;
					st_d = ddr_side_pkg::ST_SRX;
				end
			end
			ddr_side_pkg::ST_SRX: begin
				// ack falls only once the exit time has passed
				srx_d = srx_q - 8'h01;
				if (srx_q == 8'h00) begin
					sr_ack_d = 1'b0;
					srx_d = 8'h00;
					st_d = ddr_side_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d = ddr_side_pkg::ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= ddr_side_pkg::ST_IDLE;
			cmd_q <= '0;
			req_q <= '0;
			rfsh_left_q <= 4'h0;
			srx_q <= 8'h00;
			pre_sr_q <= 1'b0;
			sr_ack_q <= 1'b0;
			pd_ack_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cmd_q <= cmd_d;
			req_q <= req_d;
			rfsh_left_q <= rfsh_left_d;
			srx_q <= srx_d;
			pre_sr_q <= pre_sr_d;
			sr_ack_q <= sr_ack_d;
			pd_ack_q <= pd_ack_d;
			ready_q <= (st_d == ddr_side_pkg::ST_IDLE);
		end
	end

	// idle counter, cleared by any queued or requested work
	always_ff @(posedge clk) begin
		if (!nrst) idle_cnt_q <= `IDLE_CNT_RST;
		else if (!quiet) idle_cnt_q <= `IDLE_CNT_RST;
		else if (idle_cnt_q != pd_cyc) idle_cnt_q <= idle_cnt_q + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////
	// read return and ecc status

	// read stage and user read outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_v_q <= 1'b0;
			s1_code_q <= '0;
			rdv_q <= 1'b0;
			rde_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			s1_v_q <= phy_rd_valid;
			s1_code_q <= phy_rd_code;
			rdv_q <= rd_done && (st_q == ddr_side_pkg::ST_RD);
			rde_q <= dbe_w && (st_q == ddr_side_pkg::ST_RD);
			rdata_q <= rd_data;
		end
	end

	// interrupt, sticky flag (set wins), counters, address
	always_ff @(posedge clk) begin
		if (!nrst) begin
			irq_q <= 1'b0;
			sbe_flag_q <= 1'b0;
			sbe_cnt_q <= 16'h0000;
			dbe_cnt_q <= 16'h0000;
			err_addr_q <= '0;
		end else begin
			irq_q <= sbe_w || dbe_w;
			sbe_flag_q <= sbe_w || (sbe_flag_q && !sbe_flag_clr);
			if (sbe_w && !(&sbe_cnt_q)) sbe_cnt_q <= sbe_cnt_q + 16'h0001;
			if (dbe_w && !(&dbe_cnt_q)) dbe_cnt_q <= dbe_cnt_q + 16'h0001;
			if (sbe_w || dbe_w) err_addr_q <= req_q.addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign user_ready = ready_q;
	assign self_rfsh_ack = sr_ack_q;
	assign powerdown_ack = pd_ack_q;
	assign rdata_valid = rdv_q;
	assign rdata = rdata_q;
	assign rdata_error = rde_q;
	assign ecc_interrupt = irq_q;
	assign single_bit_flag_reg = sbe_flag_q;
	assign sbe_count = sbe_cnt_q;
	assign dbe_count = dbe_cnt_q;
	assign err_addr = err_addr_q;
	assign mem_cmd = cmd_q;

	////////////////////////////////////////////////////////////////////////////
	// assertions and covers

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_rfsh_first;
		(st_q == ddr_side_pkg::ST_IDLE && user_rfsh_req) |=> st_q == ddr_side_pkg::ST_RFSH;
	endproperty
	a_rfsh_first: assert property (p_rfsh_first) else $error("refresh not first");
	property p_rfsh_max;
		st_q == ddr_side_pkg::ST_RFSH |-> rfsh_left_q <= 4'h9 && rfsh_left_q != 4'h0;
	endproperty
	a_rfsh_max: assert property (p_rfsh_max) else $error("refresh run out of range");
	property p_rfsh_all;
		(cmd_q.kind == ddr_side_pkg::MC_REF && mc_ok) |-> &cmd_q.cs;
	endproperty
	a_rfsh_all: assert property (p_rfsh_all) else $error("multicast refresh not to all");
	property p_mc_wr;
		(take && user_req.is_wr && user_req.mc && mc_ok) |=> cmd_q.kind == ddr_side_pkg::MC_WR
			&& &cmd_q.cs;
	endproperty
	a_mc_wr: assert property (p_mc_wr) else $error("multicast write not to all");
	property p_mc_off;
		(take && user_req.is_wr && rdimm && !ecc_en) |=> cmd_q.cs == $past(user_req.cs);
	endproperty
	a_mc_off: assert property (p_mc_off) else $error("multicast used with rdimm");
	property p_sre_clean;
		cmd_q.kind == ddr_side_pkg::MC_SRE |-> $past(st_q, 2) == ddr_side_pkg::ST_IDLE;
	endproperty
	a_sre_clean: assert property (p_sre_clean) else $error("self-refresh with work open");
	property p_sr_hold;
		(st_q == ddr_side_pkg::ST_SREF && self_rfsh_req) |=> sr_ack_q [*2];
	endproperty
	a_sr_hold: assert property (p_sr_hold) else $error("self-refresh ack lost");
	property p_sr_exit;
		$fell(sr_ack_q) |-> $past(st_q) == ddr_side_pkg::ST_SRX && $past(srx_q) == 8'h00;
	endproperty
	a_sr_exit: assert property (p_sr_exit) else $error("ack dropped before exit");
	property p_pd_time;
		pd_go |=> cmd_q.kind == ddr_side_pkg::MC_PRE ##1 cmd_q.kind == ddr_side_pkg::MC_PDE;
	endproperty
	a_pd_time: assert property (p_pd_time) else $error("power-down entry wrong");
	property p_idle_clr;
		user_valid |=> idle_cnt_q == 16'h0000;
	endproperty
	a_idle_clr: assert property (p_idle_clr) else $error("idle count ran with work");
	property p_pd_ack;
		cmd_q.kind == ddr_side_pkg::MC_PDE |-> pd_ack_q ##1 (pd_ack_q || cmd_q.kind == ddr_side_pkg::MC_PDX);
	endproperty
	a_pd_ack: assert property (p_pd_ack) else $error("power-down ack missing");
	property p_irq;
		(sbe_w || dbe_w) |=> ecc_interrupt;
	endproperty
	a_irq: assert property (p_irq) else $error("ecc interrupt missing");
	property p_err_align;
		rdata_error |-> rdata_valid;
	endproperty
	a_err_align: assert property (p_err_align) else $error("error flag without valid");
	property p_stall;
		st_q inside {ddr_side_pkg::ST_RMW, ddr_side_pkg::ST_ENC} |-> !user_ready;
	endproperty
	a_stall: assert property (p_stall) else $error("request taken during correction");

	c_mc_write: cover property (cmd_q.kind == ddr_side_pkg::MC_WR && &cmd_q.cs);
	c_sref_cycle: cover property ($fell(sr_ack_q));
	c_rmw: cover property (st_q == ddr_side_pkg::ST_RMW ##[1:20] st_q == ddr_side_pkg::ST_ENC);
	c_pd: cover property (cmd_q.kind == ddr_side_pkg::MC_PDX);

endmodule // ddr_side_ctrl

/* File: inc/ddr_side_map.svh */
// constants: limits, reset values and timing counts of the sideband controller
`ifndef DDR_SIDE_MAP_SVH
`define DDR_SIDE_MAP_SVH
// longest run of back-to-back user refreshes
`define RFSH_MAX 4'h9
// cycles held after self-refresh exit before the ack drops
`define SRX_CYC 8'h10
// default idle cycles before automatic power-down
`define PD_CYC_DEF 16'h0100
// idle counter reset value
`define IDLE_CNT_RST 16'h0000
// unused top bit of the 40-bit codeword
`define CW_SPARE_BIT 39
`endif

/* File: inc/ddr_side_pkg.sv */
// types shared by the sideband controller
package ddr_side_pkg;
	localparam int NCS = 4;
	localparam int AW = 24;
	localparam int DW = 32;
	localparam int CW = 40;
	localparam int BW = DW / 8;
	// controller states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_RFSH = 9'h002,
		ST_RD = 9'h004,
		ST_RMW = 9'h008,
		ST_ENC = 9'h010,
		ST_PRE = 9'h020,
		ST_PDN = 9'h040,
		ST_SREF = 9'h080,
		ST_SRX = 9'h100
	} state_t;
	// memory commands toward the phy
	typedef enum logic [3:0] {
		MC_NOP = 4'h0,
		MC_RD = 4'h1,
		MC_WR = 4'h2,
		MC_REF = 4'h3,
		MC_PRE = 4'h4,
		MC_PDE = 4'h5,
		MC_PDX = 4'h6,
		MC_SRE = 4'h7,
		MC_SRX = 4'h8
	} mem_kind_t;
	// one user read or write
	typedef struct packed {
		logic is_wr;
		logic mc;
		logic [NCS-1:0] cs;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic [BW-1:0] byte_enable_vector;
	} user_req_t;
	// one command to the phy
	typedef struct packed {
		mem_kind_t kind;
		logic [NCS-1:0] cs;
		logic [AW-1:0] addr;
		logic [CW-1:0] code;
		logic [BW-1:0] be;
	} mem_cmd_t;
	// decoder result
	typedef struct packed {
		logic [DW-1:0] data;
		logic sbe;
		logic dbe;
	} ecc_dec_t;
endpackage

/* File: test/phy_model.sv */
// far-side phy model: keeps written codewords and answers reads
`timescale 1ns/1ps

module phy_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// commands in, read return out
	input wire ddr_side_pkg::mem_cmd_t mem_cmd,
	output logic phy_rd_valid,
	output logic [ddr_side_pkg::CW-1:0] phy_rd_code,
	// answer delay and one-shot bit flips
	input wire logic [3:0] lat,
	input wire logic inj,
	input wire logic [ddr_side_pkg::CW-1:0] flip
);
	logic [39:0] mem [int]; // codewords by address
	logic [39:0] dat [$]; // pending return codes
	int due [$]; // their return cycles
	logic [39:0] pend; // flips for the next read only
	int cyc; // free cycle count
	////////////////////////////////////////////////////////////////////////
	// capture commands, return reads in order after lat cycles
	always @(posedge clk) begin
		cyc++;
		if (inj) begin
			pend = flip;
		end
		if (!nrst) begin
			phy_rd_valid <= 1'b0;
			phy_rd_code <= 40'h5a5a5a5a5a;
			due.delete();
			dat.delete();
		end else begin
			if (mem_cmd.kind == ddr_side_pkg::MC_WR) begin
				mem[mem_cmd.addr] = mem_cmd.code;
			end
			if (mem_cmd.kind == ddr_side_pkg::MC_RD) begin
				due.push_back(cyc + lat);
				dat.push_back((mem.exists(mem_cmd.addr) ? mem[mem_cmd.addr] : 40'h0) ^ pend);
				pend = 40'h0;
			end
			if (due.size() > 0 && due[0] <= cyc) begin
				phy_rd_valid <= 1'b1;
				phy_rd_code <= dat.pop_front();
				void'(due.pop_front());
			end else begin
				// no stale data between returns
				phy_rd_valid <= 1'b0;
				phy_rd_code <= ~phy_rd_code;
			end
		end
	end
endmodule // phy_model

/* File: test/test_ddr_ctrl_sideband_power_ecc.sv */
// testbench for the sideband controller
`timescale 1ns/1ps
`include "ddr_side_map.svh"

module test_ddr_ctrl_sideband_power_ecc;
	logic clk, nrst, user_valid, user_ready, user_rfsh_req, self_rfsh_req;
	ddr_side_pkg::user_req_t user_req;
	logic [3:0] user_rfsh_cs, user_rfsh_cnt, lat;
	logic self_rfsh_ack, powerdown_ack, rdata_valid, rdata_error, sbe_flag_clr;
	logic [31:0] rdata, csr_cfg, rd_q;
	logic ecc_interrupt, single_bit_flag_reg, er_q, phy_rd_valid, inj;
	logic [15:0] sbe_count, dbe_count;
	logic [23:0] err_addr;
	ddr_side_pkg::mem_cmd_t mem_cmd;
	logic [39:0] phy_rd_code, flip;
	ddr_side_pkg::mem_cmd_t log [$]; // issued commands
	int cyc, t_rv, t_dv, t_srx, got, n_irq, n_lone, errors, checked;
	////////////////////////////////////////////////////////////////////////
	ddr_side_ctrl u_dut (.clk(clk), .nrst(nrst), .user_valid(user_valid),
		.user_req(user_req), .user_ready(user_ready), .user_rfsh_req(user_rfsh_req),
		.user_rfsh_cs(user_rfsh_cs), .user_rfsh_cnt(user_rfsh_cnt),
		.self_rfsh_req(self_rfsh_req), .self_rfsh_ack(self_rfsh_ack),
		.powerdown_ack(powerdown_ack), .rdata_valid(rdata_valid), .rdata(rdata),
		.rdata_error(rdata_error), .csr_cfg(csr_cfg), .sbe_flag_clr(sbe_flag_clr),
		.ecc_interrupt(ecc_interrupt), .single_bit_flag_reg(single_bit_flag_reg),
		.sbe_count(sbe_count), .dbe_count(dbe_count), .err_addr(err_addr),
		.mem_cmd(mem_cmd), .phy_rd_valid(phy_rd_valid), .phy_rd_code(phy_rd_code));
	phy_model u_phy (.clk(clk), .nrst(nrst), .mem_cmd(mem_cmd), .phy_rd_valid(phy_rd_valid),
		.phy_rd_code(phy_rd_code), .lat(lat), .inj(inj), .flip(flip));
	////////////////////////////////////////////////////////////////////////
	// clock, 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// monitor: command log, stamps, read capture
	always @(posedge clk) begin
		cyc++;
		if (mem_cmd.kind != ddr_side_pkg::MC_NOP) log.push_back(mem_cmd);
		if (mem_cmd.kind == ddr_side_pkg::MC_SRX) t_srx = cyc;
		if (phy_rd_valid) t_rv = cyc;
		if (ecc_interrupt) n_irq++;
		if (rdata_error && !rdata_valid) n_lone++;
		if (rdata_valid) begin
			t_dv = cyc;
			rd_q = rdata;
			er_q = rdata_error;
			got++;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(input string s, input logic [39:0] e, input logic [39:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic int idx(input ddr_side_pkg::mem_kind_t k);
		foreach (log[i]) if (log[i].kind == k) return i;
		return 99;
	endfunction
	function automatic int cnt(input ddr_side_pkg::mem_kind_t k);
		int n = 0;
		foreach (log[i]) if (log[i].kind == k) n++;
		return n;
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic setcsr(input logic [31:0] v);
		@(posedge clk);
		csr_cfg <= v;
	endtask
	task automatic wait_ready();
		int k = 0;
		@(negedge clk);
		while (!user_ready && k < 200) begin
			@(negedge clk);
			k++;
		end
		chk("user_ready", 1, user_ready);
	endtask
	// hold the request until taken, then release on the edge
	task automatic take();
		wait_ready();
		@(posedge clk);
		user_valid <= 1'b0;
	endtask
	task automatic drv(input logic w, m, input logic [3:0] c, input logic [23:0] a,
		input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		user_valid <= 1'b1;
		user_req <= '{w, m, c, a, d, b};
		take();
	endtask
	task automatic wait_rv(input int n);
		int k = 0;
		while (got == n && k < 100) begin
			@(negedge clk);
			k++;
		end
		chk("rdata_valid", 1, got != n);
	endtask
	task automatic rd(input logic [23:0] a);
		int n = got;
		drv(1'b0, 1'b0, 4'h1, a, 32'h0, 4'hf);
		wait_rv(n);
	endtask
	task automatic arm(input logic [39:0] f);
		@(posedge clk);
		inj <= 1'b1;
		flip <= f;
		@(posedge clk);
		inj <= 1'b0;
	endtask
	task automatic rfsh(input logic [3:0] c, input logic [3:0] n);
		wait_ready();
		@(posedge clk);
		user_rfsh_req <= 1'b1;
		user_rfsh_cs <= c;
		user_rfsh_cnt <= n;
		@(posedge clk);
		user_rfsh_req <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	// plain write then read, ecc off
	task automatic t_basic();
		log.delete();
		drv(1'b1, 1'b0, 4'h1, 24'h000010, 32'hcafe0001, 4'hf);
		idle(3);
		chk("wr cs", 4'h1, log[0].cs);
		chk("wr addr", 24'h000010, log[0].addr);
		rd(24'h000010);
		chk("rdata", 32'hcafe0001, rd_q);
		chk("rd latency", 1, t_dv - t_rv);
		$display("test basic done");
	endtask
	// refresh beside a read, run length clamped
	task automatic t_rfsh();
		int n;
		wait_ready();
		n = got;
		log.delete();
		@(posedge clk);
		user_rfsh_req <= 1'b1;
		user_rfsh_cs <= 4'h2;
		user_rfsh_cnt <= 4'hc;
		user_valid <= 1'b1;
		user_req <= '{1'b0, 1'b0, 4'h1, 24'h000010, 32'h0, 4'hf};
		@(posedge clk);
		user_rfsh_req <= 1'b0;
		take();
		wait_rv(n);
		chk("ref run", 9, cnt(ddr_side_pkg::MC_REF));
		chk("rd after refs", 9, idx(ddr_side_pkg::MC_RD));
		for (int i = 0; i < 9; i++) chk("ref cs", 4'h2, log[i].cs);
		$display("test refresh done");
	endtask
	// multicast on refresh and write, blocked by ecc or rdimm
	task automatic t_mc();
		logic [31:0] v [2] = '{32'h5, 32'hc};
		setcsr(32'h4);
		log.delete();
		rfsh(4'h1, 4'h1);
		idle(10);
		chk("mc ref cs", 4'hf, log[0].cs);
		log.delete();
		drv(1'b1, 1'b1, 4'h2, 24'h000020, 32'h11112222, 4'hf);
		idle(4);
		chk("mc wr cs", 4'hf, log[0].cs);
		foreach (v[i]) begin
			setcsr(v[i]);
			log.delete();
			drv(1'b1, 1'b1, 4'h2, 24'h000020, 32'h11112222, 4'hf);
			idle(6);
			chk("no mc cs", 4'h2, log[idx(ddr_side_pkg::MC_WR)].cs);
		end
		setcsr(32'h0);
		$display("test multicast done");
	endtask
	// self-refresh entry after a pending write, hold, exit
	task automatic t_sr();
		int k = 0;
		wait_ready();
		log.delete();
		@(posedge clk);
		self_rfsh_req <= 1'b1;
		user_valid <= 1'b1;
		user_req <= '{1'b1, 1'b0, 4'h1, 24'h000030, 32'h33334444, 4'hf};
		take();
		while (!self_rfsh_ack && k < 50) begin
			@(negedge clk);
			k++;
		end
		chk("wr before sre", 1, idx(ddr_side_pkg::MC_WR) < idx(ddr_side_pkg::MC_SRE));
		idle(30);
		chk("sr ack held", 1, self_rfsh_ack);
		chk("no early srx", 0, cnt(ddr_side_pkg::MC_SRX));
		@(posedge clk);
		self_rfsh_req <= 1'b0;
		k = 0;
		while (self_rfsh_ack && k < 60) begin
			@(negedge clk);
			k++;
		end
		chk("sr ack drop", 0, self_rfsh_ack);
		chk("srx seen", 1, cnt(ddr_side_pkg::MC_SRX));
		chk("ack after exit", `SRX_CYC, cyc - t_srx);
		$display("test self refresh done");
	endtask
	// auto power-down after 4 idle cycles, slow read keeps it off
	task automatic t_pd();
		lat <= 4'h8;
		setcsr(32'h00040000);
		log.delete();
		rd(24'h000010);
		chk("no pde busy", 1, cnt(ddr_side_pkg::MC_PDE) == 0 ||
			idx(ddr_side_pkg::MC_PDE) < idx(ddr_side_pkg::MC_RD));
		log.delete();
		idle(2);
		chk("pd early", 0, powerdown_ack);
		idle(15);
		chk("pd ack", 1, powerdown_ack);
		chk("pre before pde", 1, idx(ddr_side_pkg::MC_PRE) < idx(ddr_side_pkg::MC_PDE));
		log.delete();
		drv(1'b1, 1'b0, 4'h1, 24'h000040, 32'h44445555, 4'hf);
		idle(2);
		chk("pd wake", 0, powerdown_ack);
		chk("pdx first", 1, idx(ddr_side_pkg::MC_PDX) < idx(ddr_side_pkg::MC_WR));
		setcsr(32'h0);
		lat <= 4'h2;
		$display("test power down done");
	endtask
	// ecc: latency, correction, double error, partial writes
	task automatic t_ecc();
		logic [31:0] d1;
		int i0;
		setcsr(32'h3);
		drv(1'b1, 1'b0, 4'h1, 24'h000050, 32'h89abcdef, 4'hf);
		rd(24'h000050);
		chk("ecc rd lat", 2, t_dv - t_rv);
		arm(40'h20);
		i0 = n_irq;
		log.delete();
		rd(24'h000050);
		d1 = rd_q;
		rd(24'h000050);
		chk("sbe data", 32'h89abcdef, d1);
		chk("fix read", ddr_side_pkg::MC_RD, log[1].kind);
		chk("fix write", ddr_side_pkg::MC_WR, log[2].kind);
		chk("fix addr", 24'h000050, log[2].addr);
		chk("stalled rd", ddr_side_pkg::MC_RD, log[3].kind);
		chk("sbe irq", 1, n_irq - i0);
		chk("sbe count", 16'h0001, sbe_count);
		chk("sbe flag", 1, single_bit_flag_reg);
		chk("err addr", 24'h000050, err_addr);
		arm(40'h60);
		log.delete();
		rd(24'h000050);
		idle(6);
		chk("dbe error", 1, er_q);
		chk("lone error", 0, n_lone);
		chk("dbe no fix", 0, cnt(ddr_side_pkg::MC_WR));
		chk("dbe count", 16'h0001, dbe_count);
		chk("dbe irq", 2, n_irq - i0);
		arm(40'h20);
		log.delete();
		drv(1'b1, 1'b0, 4'h1, 24'h000050, 32'h0, 4'h0);
		idle(12);
		chk("rmw read", ddr_side_pkg::MC_RD, log[0].kind);
		chk("rmw write", ddr_side_pkg::MC_WR, log[1].kind);
		chk("rmw sbe", 16'h0002, sbe_count);
		drv(1'b1, 1'b0, 4'h1, 24'h000050, 32'h00000012, 4'h1);
		rd(24'h000050);
		chk("merge", 32'h89abcd12, rd_q);
		arm(40'h60);
		log.delete();
		drv(1'b1, 1'b0, 4'h1, 24'h000050, 32'h56000000, 4'h8);
		idle(12);
		chk("rmw dbe", 16'h0002, dbe_count);
		chk("rmw dbe wr", 1, cnt(ddr_side_pkg::MC_WR));
		@(posedge clk);
		sbe_flag_clr <= 1'b1;
		@(posedge clk);
		sbe_flag_clr <= 1'b0;
		idle(2);
		chk("flag clear", 0, single_bit_flag_reg);
		$display("test ecc done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// watchdog, well beyond the expected run
	initial begin
		#200000;
		errors++;
		results();
	end
	// main sequence
	initial begin
		nrst = 1'b0;
		user_valid = 1'b0;
		user_req = '0;
		user_rfsh_req = 1'b0;
		user_rfsh_cs = 4'h0;
		user_rfsh_cnt = 4'h0;
		self_rfsh_req = 1'b0;
		csr_cfg = 32'h0;
		sbe_flag_clr = 1'b0;
		lat = 4'h2;
		inj = 1'b0;
		flip = 40'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		t_basic();
		t_rfsh();
		t_mc();
		t_sr();
		t_pd();
		t_ecc();
		results();
	end
endmodule // test_ddr_ctrl_sideband_power_ecc
